// ===== ssf_top.sv
// Purpose: Serial slave that returns a status byte and 16 data bits in each 24-bit frame.
// Assumes: sck is the host's clock and only runs inside frames; select_low is low in a frame.
// Notes:   Register words cross to the link by being stable while a frame runs.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Frame is 24 bits under select low
// - Both lines carry most significant bit first
// - Sample input on rise, change output on fall
// - Deselected output released; select low enables transfer
// - Select low without clock shows error flag
// - Clockless polling never sets frame error
// - Command holds opcode 23:22, address 21:16
// - Opcodes write, read, read-clear, device info
// - Write/read hit RAM, info hits ROM
// - Read-clear returns status then clears it
// - Status byte first, then two data bytes
// - Write answers with previous register content
// - Error flag ORs faults, supply and pin
// - Frame error unless zero or exactly 24 clocks
// - Reset indicator low until first good frame
// - Bit 20 shows LED overcurrent
// - Bit 19 shows LED temperature warning
// - Bit 18 ORs LED and input overvoltage
// - Bit 17 ORs micro supply errors
// - Bit 16 limp home or long undervoltage
// - Status frozen while a frame runs
// - Unused address returns zero data
// - Read-clear at 3Fh clears all, returns configuration
module ssf_top
	import ssf_pkg::*;
#(
	parameter int          UV_HOLD_CYCLES = UV_HOLD_CYC,
	parameter logic [15:0] ID_HEADER_VAL  = 16'h1a00, // arbitrary value
	parameter logic [15:0] VERSION_VAL    = 16'h0a00, // arbitrary value
	parameter logic [15:0] PRODUCT1_VAL   = 16'h2b00, // arbitrary value
	parameter logic [15:0] PRODUCT2_VAL   = 16'h3c00  // arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        sck,
	input  wire logic        select_low,
	input  wire logic        serial_in_line,
	output var  logic        serial_out_line,
	output var  logic        serial_out_line_oe_n,
	input  wire logic        led_overcurrent_evt,
	input  wire logic        led_temp_warning,
	input  wire logic        led_chain_overvoltage_flag,
	input  wire logic        input_overvoltage_pin,
	input  wire logic        regulated_micro_supply_err,
	input  wire logic        regulated_micro_supply_uv,
	input  wire logic        supply_undervoltage_flag,
	input  wire logic        limp_home_active,
	input  wire logic        limp_pin_error,
	output var  logic [15:0] control_reg1,
	output var  logic [15:0] control_reg2,
	output var  logic [15:0] control_reg3,
	output var  logic [15:0] configuration_register
);

	// ---------------- Link domain: input side (sck rising) ----------------
	logic        link_rst;
	logic        fresh_q;
	logic        frame_tog_q;
	logic [4:0]  in_cnt_q;
	logic [4:0]  in_cur;
	logic [23:0] in_shift_q;
	logic [7:0]  cmd_q;

	assign link_rst = sys_rst | select_low;

	// Marks the first rising edge of each frame
	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	assign in_cur = fresh_q ? 5'h00 : in_cnt_q;

	// Count and bits survive select rising, so the system side reads them afterwards
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			in_cnt_q    <= 5'h00;
			in_shift_q  <= 24'h000000;
			frame_tog_q <= 1'b0;
		end else begin
			in_cnt_q   <= (in_cur == CNT_MAX) ? CNT_MAX : in_cur + 5'h01;
			in_shift_q <= {in_shift_q[22:0], serial_in_line};
			if (fresh_q) begin
				frame_tog_q <= ~frame_tog_q;
			end
		end
	end

	// Command byte is complete at the eighth rising edge
	always_ff @(posedge sck or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_q <= 8'h00;
		end else if (in_cur == CMD_LAST) begin
			cmd_q <= {in_shift_q[6:0], serial_in_line};
		end
	end

	// ---------------- Link domain: output side ----------------
	// Rises on select falling (clock low) and on every sck falling edge
	logic        out_clk;
	logic [4:0]  out_idx_q;
	logic [23:0] resp_word;
	logic [15:0] resp_data;
	logic [7:0]  gsb_q;
	logic [15:0] ctrl_q [CTRL_N];
	logic [15:0] cfg_q;
	logic [8:0]  stat_q;
	logic [1:0]  cmd_op;
	logic [5:0]  cmd_adr;

	assign out_clk = ~(sck | select_low);
	assign cmd_op  = cmd_q[OP_HI:OP_LO];
	assign cmd_adr = cmd_q[ADR_HI:0];

	// Data bytes looked up from a command that is stable after edge eight
	always_comb begin
		resp_data = 16'h0000;
		if (cmd_op == OP_INFO) begin
			case (cmd_adr)
				ROM_ID:       resp_data = ID_HEADER_VAL;
				ROM_VER:      resp_data = VERSION_VAL;
				ROM_PROD1:    resp_data = PRODUCT1_VAL;
				ROM_PROD2:    resp_data = PRODUCT2_VAL;
				ROM_FRAME_ID: resp_data = ROM_FRAME_ID_VAL;
				default:      resp_data = 16'h0000;
			endcase
		end else begin
			if (cmd_adr <= ADR_CTRL3) begin
				resp_data = ctrl_q[cmd_adr[1:0]];
			end else begin
				case (cmd_adr)
					ADR_STAT1: resp_data = {9'h000, stat_q[STAT1_W-1:0]};
					ADR_STAT2: resp_data = {14'h0000, stat_q[EV_N-1:STAT1_W]};
					ADR_TRIM:  resp_data = TRIM_VAL;
					ADR_CFG:   resp_data = cfg_q;
					default:   resp_data = 16'h0000;
				endcase
			end
		end
	end

	assign resp_word = {gsb_q, resp_data};

	// Edge zero is select falling and shows the error flag before any clock
	always_ff @(posedge out_clk or posedge link_rst) begin
		if (link_rst) begin
			serial_out_line      <= 1'b0;
			serial_out_line_oe_n <= 1'b1;
			out_idx_q            <= 5'h00;
		end else begin
			serial_out_line_oe_n <= 1'b0;
			if (out_idx_q < FRAME_BITS) begin
				serial_out_line <= resp_word[LAST_BIT - out_idx_q];
				out_idx_q       <= out_idx_q + 5'h01;
			end else begin
				serial_out_line <= 1'b0;
			end
		end
	end

	// ---------------- System domain: crossings ----------------
	logic sel_s1_q;
	logic sel_s2_q;
	logic sel_s3_q;
	logic tog_s1_q;
	logic tog_s2_q;
	logic tog_seen_q;
	logic frozen;
	logic frame_end;
	logic had_clk;
	logic frame_ok;
	logic exec;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_s1_q <= 1'b1;
			sel_s2_q <= 1'b1;
			sel_s3_q <= 1'b1;
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
		end else begin
			sel_s1_q <= select_low;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
			tog_s1_q <= frame_tog_q;
			tog_s2_q <= tog_s1_q;
		end
	end

	assign frozen    = ~sel_s2_q;
	assign frame_end = sel_s2_q & ~sel_s3_q;
	assign had_clk   = tog_s2_q ^ tog_seen_q;
	assign frame_ok  = (in_cnt_q == FRAME_BITS);
	assign exec      = frame_end & had_clk & frame_ok;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tog_seen_q <= 1'b0;
		end else if (frame_end) begin
			tog_seen_q <= tog_s2_q;
		end
	end

	// ---------------- Frame error and reset indicator ----------------
	logic comm_err_q;
	logic not_reset_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			comm_err_q  <= 1'b0;
			not_reset_q <= 1'b0;
		end else if (frame_end && had_clk) begin
			comm_err_q  <= ~frame_ok;
			not_reset_q <= frame_ok;
		end
	end

	// ---------------- RAM registers ----------------
	genvar gi;
	generate
		for (gi = 0; gi < CTRL_N; gi++) begin : g_ctrl
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					ctrl_q[gi] <= CTRL_RST[gi];
				end else if (exec && cmd_op == OP_WRITE && cmd_adr == 6'(gi)) begin
					ctrl_q[gi] <= in_shift_q[15:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= CFG_RST;
		end else if (exec && cmd_op == OP_WRITE && cmd_adr == ADR_CFG) begin
			cfg_q <= in_shift_q[15:0];
		end
	end

	assign control_reg1           = ctrl_q[1];
	assign control_reg2           = ctrl_q[2];
	assign control_reg3           = ctrl_q[3];
	assign configuration_register = cfg_q;

	// ---------------- Event inputs and sticky status ----------------
	logic [EV_N-1:0]     ev_raw;
	logic [EV_N-1:0]     ev_s1_q;
	logic [EV_N-1:0]     ev_s2_q;
	logic [EV_N-1:0]     ev_in;
	logic [EV_N-1:0]     pend_q;
	logic [EV_N-1:0]     stat_clr;
	logic [EV_N-1:0]     stat_set;
	logic [UV_CNT_W-1:0] uv_cnt_q;
	logic                uv_long_q;

	always_comb begin
		ev_raw           = '0;
		ev_raw[EV_OC]    = led_overcurrent_evt;
		ev_raw[EV_TEMP]  = led_temp_warning;
		ev_raw[EV_LEDOV] = led_chain_overvoltage_flag;
		ev_raw[EV_INPOV] = input_overvoltage_pin;
		ev_raw[EV_VCCER] = regulated_micro_supply_err;
		ev_raw[EV_VCCUV] = regulated_micro_supply_uv;
		ev_raw[EV_VSUV]  = supply_undervoltage_flag;
		ev_raw[EV_LIMP]  = limp_home_active;
		ev_raw[EV_LPERR] = limp_pin_error;
	end

	generate
		for (gi = 0; gi < EV_N; gi++) begin : g_ev_sync
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					ev_s1_q[gi] <= 1'b0;
					ev_s2_q[gi] <= 1'b0;
				end else begin
					ev_s1_q[gi] <= ev_raw[gi];
					ev_s2_q[gi] <= ev_s1_q[gi];
				end
			end
		end
	endgenerate

	// Undervoltage of the micro supply counts only once it outlasts the hold time
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			uv_cnt_q  <= '0;
			uv_long_q <= 1'b0;
		end else if (!ev_s2_q[EV_VCCUV]) begin
			uv_cnt_q  <= '0;
			uv_long_q <= 1'b0;
		end else if (uv_cnt_q == UV_CNT_W'(UV_HOLD_CYCLES)) begin
			uv_long_q <= 1'b1;
		end else begin
			uv_cnt_q <= uv_cnt_q + UV_CNT_W'(1);
		end
	end

	always_comb begin
		ev_in           = ev_s2_q;
		ev_in[EV_VCCUV] = uv_long_q;
	end

	always_comb begin
		stat_clr = '0;
		if (exec && cmd_op == OP_RDCLR) begin
			case (cmd_adr)
				ADR_STAT1: stat_clr = STAT1_MASK;
				ADR_STAT2: stat_clr = STAT2_MASK;
				ADR_CFG:   stat_clr = STAT_ALL;
				default:   stat_clr = '0;
			endcase
		end
	end

	// Events seen during a frame wait in pend_q and land once it ends
	assign stat_set = frozen ? '0 : (pend_q | ev_in);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_q <= '0;
		end else if (frozen) begin
			pend_q <= pend_q | ev_in;
		end else begin
			pend_q <= '0;
		end
	end

	// A set in the same cycle as a clear wins
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_q <= STAT_RST;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
		end
	end

	// ---------------- Status summary byte ----------------
	logic [7:0] gsb_d;

	always_comb begin
		gsb_d           = 8'h00;
		gsb_d[GSB_COMM] = comm_err_q;
		gsb_d[GSB_NRST] = not_reset_q;
		gsb_d[GSB_OVL]  = stat_q[EV_OC];
		gsb_d[GSB_TEMP] = stat_q[EV_TEMP];
		gsb_d[GSB_OV]   = stat_q[EV_LEDOV] | stat_q[EV_INPOV];
		gsb_d[GSB_VCC]  = stat_q[EV_VCCER] | stat_q[EV_VCCUV];
		gsb_d[GSB_FS]   = stat_q[EV_LIMP] | stat_q[EV_VCCUV];
		gsb_d[GSB_GEF]  = comm_err_q | (|gsb_d[GSB_OVL:GSB_FS]) | stat_q[EV_VSUV]
			| stat_q[EV_LPERR];
	end

	// Held still during a frame so the link reads a steady byte
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gsb_q <= 8'h00;
		end else if (!frozen) begin
			gsb_q <= gsb_d;
		end
	end

endmodule : ssf_top

`default_nettype wire

// ===== ssf_pkg.sv
// Purpose: Shared constants of the 24-bit serial slave with status frame.
// Assumes: System clock of 10 MHz; frame is 8 command bits then 16 data bits.
// Notes:   Offsets, field positions, reset values and timing counts live here only.
`default_nettype none

package ssf_pkg;

	// Operation codes, high bit first
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ  = 2'h1;
	localparam logic [1:0] OP_RDCLR = 2'h2;
	localparam logic [1:0] OP_INFO  = 2'h3;

	// RAM space
	localparam logic [5:0] ADR_RSVD  = 6'h00;
	localparam logic [5:0] ADR_CTRL3 = 6'h03;
	localparam logic [5:0] ADR_STAT1 = 6'h04;
	localparam logic [5:0] ADR_STAT2 = 6'h05;
	localparam logic [5:0] ADR_TRIM  = 6'h3e;
	localparam logic [5:0] ADR_CFG   = 6'h3f;

	// ROM space
	localparam logic [5:0] ROM_ID       = 6'h00;
	localparam logic [5:0] ROM_VER      = 6'h01;
	localparam logic [5:0] ROM_PROD1    = 6'h02;
	localparam logic [5:0] ROM_PROD2    = 6'h03;
	localparam logic [5:0] ROM_FRAME_ID = 6'h3e;

	localparam logic [15:0] ROM_FRAME_ID_VAL = 16'h4200;
	localparam logic [15:0] TRIM_VAL         = 16'h0000;

	// Reset values of RAM registers 00h..03h and 3Fh
	localparam int          CTRL_N        = 4;
	localparam logic [15:0] CTRL_RST [4] = '{16'h0000, 16'h000e, 16'h5e1f, 16'h0000};
	localparam logic [15:0] CFG_RST       = 16'h0000;

	// Frame layout
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [4:0] LAST_BIT   = 5'h17;
	localparam logic [4:0] CMD_LAST   = 5'h07;
	localparam logic [4:0] CNT_MAX    = 5'h1f;
	localparam int         OP_HI      = 7;
	localparam int         OP_LO      = 6;
	localparam int         ADR_HI     = 5;

	// Status summary byte positions
	localparam int GSB_GEF  = 7;
	localparam int GSB_COMM = 6;
	localparam int GSB_NRST = 5;
	localparam int GSB_OVL  = 4;
	localparam int GSB_TEMP = 3;
	localparam int GSB_OV   = 2;
	localparam int GSB_VCC  = 1;
	localparam int GSB_FS   = 0;

	// Sticky event bits: 0..6 form status register 1, 7..8 status register 2
	localparam int EV_OC    = 0;
	localparam int EV_TEMP  = 1;
	localparam int EV_LEDOV = 2;
	localparam int EV_INPOV = 3;
	localparam int EV_VCCER = 4;
	localparam int EV_VCCUV = 5;
	localparam int EV_VSUV  = 6;
	localparam int EV_LIMP  = 7;
	localparam int EV_LPERR = 8;
	localparam int EV_N     = 9;
	localparam int STAT1_W  = 7;
	localparam int STAT2_W  = 2;
	localparam logic [8:0] STAT1_MASK = 9'h07f;
	localparam logic [8:0] STAT2_MASK = 9'h180;
	localparam logic [8:0] STAT_ALL   = 9'h1ff;
	localparam logic [8:0] STAT_RST   = 9'h000;

	// Micro supply undervoltage must persist this long to count as fail-safe
	localparam int CLK_HZ      = 10_000_000;
	localparam int UV_HOLD_US  = 2000;
	localparam int UV_HOLD_CYC = UV_HOLD_US * (CLK_HZ / 1_000_000);
	localparam int UV_CNT_W    = 15;

endpackage : ssf_pkg

`default_nettype wire

// ===== ssf_top_properties.sv
// Purpose: Port-level properties of the serial status-frame slave.
// Assumes: Frames are spaced so register updates land between them.
// Notes:   Bound to ssf_top; two link properties use the host clock, the other properties use the system clock.
`timescale 1ns/100ps
`default_nettype none
module ssf_top_checker
	import ssf_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        sck,
	input wire logic        select_low,
	input wire logic        serial_out_line,
	input wire logic        serial_out_line_oe_n,
	input wire logic [15:0] control_reg1,
	input wire logic [15:0] control_reg2,
	input wire logic [15:0] control_reg3,
	input wire logic [15:0] configuration_register
);
	logic [4:0] sck_cnt_q;

	// Clock rises seen in the current frame
	always_ff @(posedge sck or posedge select_low) begin
		if (select_low) begin
			sck_cnt_q <= 5'h00;
		end else if (sck_cnt_q != CNT_MAX) begin
			sck_cnt_q <= sck_cnt_q + 5'h01;
		end
	end

	chk_release_out:
	assert property (@(posedge clk) disable iff (sys_rst) select_low |-> serial_out_line_oe_n)
		else $error("output driven while deselected");
	chk_drive_selected:
	assert property (@(posedge clk) disable iff (sys_rst)
		!select_low && !$past(select_low) |-> !serial_out_line_oe_n)
		else $error("output not driven while selected");
	chk_drive_in_frame:
	assert property (@(posedge sck) disable iff (sys_rst) !select_low |-> !serial_out_line_oe_n)
		else $error("output released at a clock rise");
	chk_tail_zero:
	assert property (@(posedge sck) disable iff (sys_rst)
		sck_cnt_q == FRAME_BITS |-> serial_out_line == 1'b0)
		else $error("output not zero past the last bit");
	chk_ctrl_frozen:
	assert property (@(posedge clk) disable iff (sys_rst) !select_low && !$past(select_low)
		|-> $stable({control_reg1, control_reg2, control_reg3}))
		else $error("control word changed during a frame");
	chk_cfg_frozen:
	assert property (@(posedge clk) disable iff (sys_rst)
		!select_low && !$past(select_low) |-> $stable(configuration_register))
		else $error("configuration changed during a frame");
	chk_reset_regs:
	assert property (@(posedge clk) sys_rst && $past(sys_rst) |-> control_reg1 == CTRL_RST[1]
		&& control_reg2 == CTRL_RST[2] && control_reg3 == CTRL_RST[3]
		&& configuration_register == CFG_RST)
		else $error("register reset value wrong");
	chk_reset_link:
	assert property (@(posedge clk) sys_rst && $past(sys_rst)
		|-> serial_out_line_oe_n && !serial_out_line)
		else $error("link output not idle in reset");
endmodule : ssf_top_checker

bind ssf_top ssf_top_checker u_chk (
	.clk(clk), .sys_rst(sys_rst), .sck(sck), .select_low(select_low),
	.serial_out_line(serial_out_line), .serial_out_line_oe_n(serial_out_line_oe_n),
	.control_reg1(control_reg1), .control_reg2(control_reg2), .control_reg3(control_reg3),
	.configuration_register(configuration_register)
);
`default_nettype wire

// ===== ssf_host_model.sv
// Purpose: Host master of the 24-bit link, clock idle low, 15 ns period.
// Assumes: Caller spaces frames; the gap after a frame is built in.
// Notes:   A released output line reads as the inverse of its last level.
`timescale 1ns/100ps
`default_nettype none
module ssf_host_model #(
	parameter realtime HALF = 7.5
) (
	output var  logic sck,
	output var  logic select_low,
	output var  logic serial_in_line,
	input  wire logic serial_out_line,
	input  wire logic serial_out_line_oe_n
);
	logic last_q;
	logic line;

	assign line = serial_out_line_oe_n ? ~last_q : serial_out_line;

	initial begin
		sck = 1'b0;
		select_low = 1'b1;
		serial_in_line = 1'b0;
		last_q = 1'b0;
	end

	always @(serial_out_line) begin
		if (!serial_out_line_oe_n) begin
			last_q = serial_out_line;
		end
	end

	// Select moves only with the clock low; sample on rise, change on fall
	task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h000000;
		serial_in_line = tx[23];
		select_low = 1'b0;
		#(HALF);
		for (int i = 0; i < n; i++) begin
			if (i < 24) rx[23 - i] = line;
			sck = 1'b1;
			#(HALF);
			sck = 1'b0;
			if (i < 23) serial_in_line = tx[22 - i];
			#(HALF);
		end
		select_low = 1'b1;
		serial_in_line = ~serial_in_line;
		#500;
	endtask : frame

	task automatic poll(output logic v);
		select_low = 1'b0;
		#300;
		v = line;
		select_low = 1'b1;
		#500;
	endtask : poll
endmodule : ssf_host_model
`default_nettype wire

// ===== test_spi_slave_status_frame.sv
// Purpose: Self-checking bench of the serial status-frame slave.
// Assumes: Host model drives the link; events pulse between frames.
// Notes:   Expected frames come from a shadow of registers and flags.
`timescale 1ns/100ps
`default_nettype none
module test_spi_slave_status_frame;
	import ssf_pkg::*;
	localparam logic [15:0] ID_V [4] = '{16'h1234, 16'h0567, 16'h0789, 16'h0abc}; // arbitrary
	localparam logic [5:0] INFO_A [6] = '{ROM_ID, ROM_VER, ROM_PROD1, ROM_PROD2, ROM_FRAME_ID, 6'h07};
	localparam logic [5:0] WR_A [4] = '{6'h01, 6'h02, ADR_CTRL3, ADR_CFG};
	logic        clk, sys_rst, sck, select_low, serial_in_line, sout, sout_oe_n, bad, ok, v;
	logic [8:0]  ev, ev_st;
	logic [15:0] reg1, reg2, reg3, cfg_port, cfg;
	logic [15:0] shadow [4];
	logic [31:0] lfsr_q;
	logic [5:0]  sa;
	int          fails, compares, cyc;

	ssf_top #(.UV_HOLD_CYCLES(20), .ID_HEADER_VAL(ID_V[0]), .VERSION_VAL(ID_V[1]),
		.PRODUCT1_VAL(ID_V[2]), .PRODUCT2_VAL(ID_V[3])) dut (
		.clk(clk), .sys_rst(sys_rst), .sck(sck), .select_low(select_low),
		.serial_in_line(serial_in_line), .serial_out_line(sout), .serial_out_line_oe_n(sout_oe_n),
		.led_overcurrent_evt(ev[EV_OC]), .led_temp_warning(ev[EV_TEMP]),
		.led_chain_overvoltage_flag(ev[EV_LEDOV]), .input_overvoltage_pin(ev[EV_INPOV]),
		.regulated_micro_supply_err(ev[EV_VCCER]), .regulated_micro_supply_uv(ev[EV_VCCUV]),
		.supply_undervoltage_flag(ev[EV_VSUV]), .limp_home_active(ev[EV_LIMP]),
		.limp_pin_error(ev[EV_LPERR]), .control_reg1(reg1), .control_reg2(reg2),
		.control_reg3(reg3), .configuration_register(cfg_port));
	ssf_host_model host (.sck(sck), .select_low(select_low), .serial_in_line(serial_in_line),
		.serial_out_line(sout), .serial_out_line_oe_n(sout_oe_n));

	always #50 clk = ~clk;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	function automatic logic [7:0] gsb(input logic [8:0] s, input logic e, input logic g);
		logic [4:0] b;
		b = {s[EV_OC], s[EV_TEMP], s[EV_LEDOV] | s[EV_INPOV], s[EV_VCCER] | s[EV_VCCUV],
			s[EV_LIMP] | s[EV_VCCUV]};
		return {e | (|b) | s[EV_VSUV] | s[EV_LPERR], e, g, b};
	endfunction : gsb

	function automatic logic [15:0] rd_val(input logic [1:0] op, input logic [5:0] a);
		if (op == OP_INFO) begin
			if (a <= ROM_PROD2) return ID_V[a[1:0]];
			return (a == ROM_FRAME_ID) ? ROM_FRAME_ID_VAL : 16'h0000;
		end
		if (a <= ADR_CTRL3) return shadow[a[1:0]];
		case (a)
			ADR_STAT1: return {9'h000, ev_st[6:0]};
			ADR_STAT2: return {14'h0000, ev_st[8:7]};
			ADR_TRIM:  return TRIM_VAL;
			ADR_CFG:   return cfg;
			default:   return 16'h0000;
		endcase
	endfunction : rd_val

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic run(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
		input int n);
		logic [23:0] rx;
		logic [23:0] exp;
		exp = {gsb(ev_st, bad, ok), rd_val(op, a)};
		@(negedge clk);
		host.frame({op, a, d}, n, rx);
		repeat (8) @(negedge clk);
		if (n >= 24) check(rx, exp);
		if (n == 24 && op == OP_WRITE && a <= ADR_CTRL3) shadow[a[1:0]] = d;
		if (n == 24 && op == OP_WRITE && a == ADR_CFG) cfg = d;
		if (n == 24 && op == OP_RDCLR) begin
			ev_st &= (a == ADR_STAT1) ? ~STAT1_MASK : (a == ADR_STAT2) ? ~STAT2_MASK :
				(a == ADR_CFG) ? ~STAT_ALL : STAT_ALL;
		end
		bad = (n != 24);
		ok = (n == 24);
	endtask : run

	task automatic poll;
		logic [7:0] g;
		g = gsb(ev_st, bad, ok);
		@(negedge clk);
		host.poll(v);
		check({23'h000000, v}, {23'h000000, g[7]});
	endtask : poll

	task automatic pulse(input logic [8:0] m);
		@(negedge clk);
		ev = m;
		repeat (3) @(negedge clk);
		ev = 9'h000;
		repeat (6) @(negedge clk);
		ev_st |= m;
	endtask : pulse

	task automatic test_done;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done

	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		ev = 9'h000;
		ev_st = STAT_RST;
		shadow = CTRL_RST;
		cfg = CFG_RST;
		bad = 1'b0;
		ok = 1'b0;
		lfsr_q = 32'h898c17ea;
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		repeat (5) @(negedge clk);
		run(OP_INFO, ROM_FRAME_ID, 16'h0000, 24);
		foreach (INFO_A[i]) run(OP_INFO, INFO_A[i], 16'hffff, 24);
		foreach (WR_A[i]) begin
			lfsr_q = lfsr_next(lfsr_q);
			run(OP_WRITE, WR_A[i], lfsr_q[15:0], 24);
			run(OP_READ, WR_A[i], 16'h0000, 24);
		end
		run(OP_WRITE, ADR_CTRL3, 16'hffff, 24);
		check({reg1, reg2[7:0]}, {shadow[1], shadow[2][7:0]});
		check({reg3, cfg_port[7:0]}, {shadow[3], cfg[7:0]});
		check({reg2, cfg_port[15:8]}, {shadow[2], cfg[15:8]});
		for (int i = 0; i < 10; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			run({lfsr_q[8], 1'b1}, lfsr_q[5:0], lfsr_q[31:16], 24);
		end
		pulse(9'h001);
		run(OP_WRITE, 6'h01, 16'h0f0f, 23);
		run(OP_RDCLR, ADR_STAT1, 16'h0000, 25);
		poll();
		run(OP_READ, ADR_STAT1, 16'h0000, 24);
		run(OP_RDCLR, ADR_STAT1, 16'h0000, 24);
		run(OP_READ, 6'h01, 16'h0000, 24);
		poll();
		run(OP_READ, 6'h01, 16'h0000, 24);
		for (int k = 0; k < EV_N; k++) begin
			if (k != EV_VCCUV) begin
				pulse(9'h001 << k);
				sa = (k < STAT1_W) ? ADR_STAT1 : ADR_STAT2;
				run(OP_READ, sa, 16'h0000, 24);
				run(OP_RDCLR, sa, 16'h0000, 24);
				run(OP_READ, sa, 16'h0000, 24);
			end
		end
		pulse(9'h101);
		run(OP_RDCLR, ADR_CFG, 16'h0000, 24);
		run(OP_READ, ADR_STAT1, 16'h0000, 24);
		run(OP_READ, ADR_STAT2, 16'h0000, 24);
		// Supply dip shorter than the hold time leaves no trace
		ev[EV_VCCUV] = 1'b1;
		repeat (10) @(negedge clk);
		ev[EV_VCCUV] = 1'b0;
		run(OP_READ, ADR_STAT1, 16'h0000, 24);
		ev[EV_VCCUV] = 1'b1;
		repeat (40) @(negedge clk);
		ev[EV_VCCUV] = 1'b0;
		ev_st[EV_VCCUV] = 1'b1;
		run(OP_READ, ADR_STAT1, 16'h0000, 24);
		run(OP_RDCLR, ADR_STAT1, 16'h0000, 24);
		run(OP_READ, ADR_STAT1, 16'h0000, 24);
		// Reset in mid-run brings the reset indicator and registers back
		sys_rst = 1'b1;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		ev_st = STAT_RST;
		shadow = CTRL_RST;
		cfg = CFG_RST;
		bad = 1'b0;
		ok = 1'b0;
		repeat (3) @(negedge clk);
		run(OP_READ, 6'h02, 16'h0000, 24);
		run(OP_READ, ADR_CFG, 16'h0000, 24);
		test_done();
	end
endmodule : test_spi_slave_status_frame
`default_nettype wire
